//--- inc/qdc_pkg.sv
// Purpose: shared constants and types of the quad converter serial front end
// Assumes: 125 MHz system clock samples every pin
// Notes: word layout is channel in the top two bits, code in the low twelve
`default_nettype none
package qdc_pkg;
  localparam int WORD_W = 16;
  localparam int CODE_W = 12;
  localparam int CHAN_N = 4;
  localparam int FIFO_DEPTH = 8;
  localparam logic [4:0] BIT_CNT_RST = 5'h00;
  localparam logic [4:0] BIT_CNT_LAST = 5'h0F;
  localparam logic [WORD_W-1:0] SHIFT_RST = 16'h0000;
  localparam logic [CODE_W-1:0] CODE_ZERO = 12'h000;
  localparam logic [CODE_W-1:0] CODE_MID = 12'h800;
  localparam int CLK_PERIOD_NS = 8;
  localparam int LOAD_PULSE_NS = 20;
  localparam int LOAD_PULSE_CYC = (LOAD_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // raw pin levels, also used for the synchroniser stages
  typedef struct packed {
    logic data;
    logic sclk;
    logic select_n;
    logic load_n;
    logic clear_n;
    logic clear_level;
  } qdc_pins_t;

  localparam qdc_pins_t PINS_RST = '{data: 1'b0, sclk: 1'b1, select_n: 1'b1, load_n: 1'b1, clear_n: 1'b1,
                                     clear_level: 1'b0};

  // one serial frame, msb first on the wire
  typedef struct packed {
    logic [1:0] chan;
    logic [1:0] spare;
    logic [CODE_W-1:0] code;
  } qdc_word_t;

  typedef logic [CHAN_N-1:0][CODE_W-1:0] qdc_codes_t;

  function automatic logic [CODE_W-1:0] qdc_clear_code(input logic level);
    qdc_clear_code = level ? CODE_MID : CODE_ZERO;
  endfunction
endpackage
`default_nettype wire

//--- verification/qdc_front_test.sv
// Purpose: self-checking bench of the converter front end
// Assumes: clock enable tied high
// Notes: writes are stalled by holding clear, not load, so the host never shifts during a load
`default_nettype none
module qdc_front_test;
  timeunit 1ns;
  timeprecision 100ps;
  import qdc_pkg::*;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic load_outputs_n = 1'b1;
  logic clear_n = 1'b1;
  logic clear_level_select = 1'b0;
  logic link_busy;
  wire logic sdata;
  wire logic sclk;
  wire logic sel_n;
  qdc_codes_t dac_codes, input_codes, exp_in, exp_dac, held;
  int error_cnt = 0;
  int tests_run = 0;
  int seed = 32'ha762;

  qdc_host_model u_host (.serial_data_in(sdata), .serial_clock(sclk), .select_n(sel_n));
  qdc_front u_dut (.clock(clock), .reset_n(reset_n), .clk_en(1'b1), .serial_data_in(sdata),
    .serial_clock(sclk), .select_n(sel_n), .load_outputs_n(load_outputs_n), .clear_n(clear_n),
    .clear_level_select(clear_level_select), .dac_codes(dac_codes), .input_codes(input_codes),
    .link_busy(link_busy));

  initial begin
    forever #4 clock = ~clock;
  end

  task automatic stop_test();
    $display("errors %0d checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic cmp_codes(input qdc_codes_t got, input qdc_codes_t exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic settle();
    int n;
    n = 0;
    while ((input_codes !== exp_in || dac_codes !== exp_dac) && n < 40) begin
      @(posedge clock);
      #1;
      n++;
    end
    // bound used up without a match counts as a failure
    if (input_codes !== exp_in || dac_codes !== exp_dac) begin
      error_cnt++;
      stop_test();
    end
  endtask

  task automatic send_random();
    logic [15:0] w;
    w = 16'($random(seed));
    u_host.send_word(w, 1'b0);
    exp_in[w[15:14]] = w[CODE_W-1:0];
  endtask

  task automatic pulse_load();
    @(posedge clock);
    #1 load_outputs_n = 1'b0;
    repeat (4) @(posedge clock);
    #1 load_outputs_n = 1'b1;
    exp_dac = exp_in;
    settle();
  endtask

  initial begin
    exp_in = '0;
    exp_dac = '0;
    repeat (20) @(posedge clock);
    #1 reset_n = 1'b1;
    cmp_codes(dac_codes, exp_dac);
    repeat (4) @(posedge clock);
    for (int i = 0; i < 8; i++) begin
      send_random();
    end
    settle();
    cmp_codes(input_codes, exp_in);
    cmp_codes(dac_codes, exp_dac);
    u_host.send_word(16'hFFFF, 1'b1);
    repeat (10) @(posedge clock);
    #1;
    cmp_codes(input_codes, exp_in);
    pulse_load();
    cmp_codes(dac_codes, exp_dac);
    for (int lvl = 0; lvl < 2; lvl++) begin
      @(posedge clock);
      #1 clear_level_select = lvl[0];
      clear_n = 1'b0;
      for (int c = 0; c < CHAN_N; c++) begin
        exp_in[c] = lvl[0] ? 12'h800 : 12'h000;
      end
      exp_dac = exp_in;
      held = exp_in;
      repeat (6) @(posedge clock);
      #1;
      cmp_codes(input_codes, exp_in);
      cmp_codes(dac_codes, exp_dac);
      // nine words: eight in the buffer, one waiting
      for (int i = 0; i < 9; i++) begin
        send_random();
      end
      repeat (8) @(posedge clock);
      #1;
      cmp_codes(input_codes, held);
      cmp_bit(link_busy, 1'b1);
      @(posedge clock);
      #1 clear_n = 1'b1;
      settle();
      cmp_codes(input_codes, exp_in);
      cmp_codes(dac_codes, exp_dac);
      cmp_bit(link_busy, 1'b0);
      pulse_load();
      cmp_codes(dac_codes, exp_dac);
    end
    stop_test();
  end
endmodule
`default_nettype wire

//--- verification/qdc_host_model.sv
// Purpose: host end of the serial link
// Assumes: shift clock of 125 ns period, idle high between frames
// Notes: a released data pin shows the inverse of its last bit
`default_nettype none
module qdc_host_model (
  // serial link
  output var logic serial_data_in,
  output var logic serial_clock,
  output var logic select_n
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    serial_data_in = 1'b0;
    serial_clock = 1'b1;
    select_n = 1'b1;
  end
  task automatic send_word(input logic [15:0] word, input logic desel);
    select_n = desel;
    #20;
    for (int i = 15; i >= 0; i--) begin
      serial_clock = 1'b0;
      serial_data_in = word[i];
      #62.5;
      serial_clock = 1'b1;
      #62.5;
    end
    #20;
    select_n = 1'b1;
    serial_data_in = ~serial_data_in;
    // deselect must last long enough for the synchroniser to see it
    #40;
  endtask
endmodule
`default_nettype wire

//--- verilog/qdc_front.sv
// Purpose: serial load, load strobe and clear logic of a quad 12-bit converter
// Assumes: all pins asynchronous to clock; pins sampled by two flip-flops each
// Notes: serial clock must stay well below clock/4 so every edge is seen
//
// What this block does
// RULE_01: host keeps data valid at every rising serial clock edge.
// RULE_02: data input ignored while select is high.
// RULE_03: each rising serial clock edge while selected shifts one bit in.
// RULE_04: host holds select low for the whole frame.
// RULE_05: internal shift clock is select ORed with serial clock.
// RULE_06: load strobe falling edge copies input registers to converter registers.
// RULE_07: host keeps input data still while load strobe is low.
// RULE_08: clear forces input and converter registers to the clear code.
// RULE_09: clear leaves the serial shift register untouched.
// RULE_10: clear code is midscale when level select high, else zero.
// RULE_11: a frame is one 16-bit word.
// RULE_12: word is channel bits 15:14, code bits 11:0, msb first.
`default_nettype none

module qdc_fifo
  import qdc_pkg::*;
#(
  parameter int WIDTH = WORD_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clk_en,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic push, pop;

  assign in_ready = (cnt_r != FULL_CNT);
  assign out_valid = (cnt_r != '0);
  assign out_data = mem_r[rd_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    wr_nxt = wr_r;
    rd_nxt = rd_r;
    cnt_nxt = cnt_r;
    if (push) begin
      wr_nxt = (wr_r == LAST_PTR) ? '0 : wr_r + 1'b1;
    end
    if (pop) begin
      rd_nxt = (rd_r == LAST_PTR) ? '0 : rd_r + 1'b1;
    end
    if (push && !pop) begin
      cnt_nxt = cnt_r + 1'b1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end else if (clk_en) begin
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // storage needs no reset; it is never read while empty
  always_ff @(posedge clock) begin
    if (clk_en && push) begin
      mem_r[wr_r] <= in_data;
    end
  end
endmodule

module qdc_front
  import qdc_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clk_en,
  // serial link pins
  input wire logic serial_data_in,
  input wire logic serial_clock,
  input wire logic select_n,
  // control pins
  input wire logic load_outputs_n,
  input wire logic clear_n,
  input wire logic clear_level_select,
  // converter side
  output qdc_codes_t dac_codes,
  output qdc_codes_t input_codes,
  output logic link_busy
);
  qdc_pins_t pins, sync1_r, sync2_r, prev_r;
  logic [WORD_W-1:0] shift_r, shift_nxt;
  logic [4:0] cnt_r, cnt_nxt;
  logic pend_r, pend_nxt;
  qdc_word_t pend_word_r, pend_word_nxt;
  qdc_codes_t in_reg_r, in_reg_nxt, dac_r, dac_nxt;
  logic gclk, gclk_prev, gclk_rise, load_fall, clearing;
  logic fifo_in_ready, fifo_out_valid, fifo_out_ready;
  logic [WORD_W-1:0] fifo_out_data;
  qdc_word_t head;

  assign pins = '{data: serial_data_in, sclk: serial_clock, select_n: select_n, load_n: load_outputs_n,
                  clear_n: clear_n, clear_level: clear_level_select};

  // two-stage synchroniser, then one stage of history for edge detection
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sync1_r <= PINS_RST;
      sync2_r <= PINS_RST;
      prev_r <= PINS_RST;
    end else if (clk_en) begin
      sync1_r <= pins;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end

  // RULE_05: select ORed into clock
  assign gclk = sync2_r.select_n | sync2_r.sclk;
  assign gclk_prev = prev_r.select_n | prev_r.sclk;
  assign gclk_rise = gclk && !gclk_prev;
  assign load_fall = prev_r.load_n && !sync2_r.load_n;
  assign clearing = !sync2_r.clear_n;

  // shifter: frame state resets whenever select is high
  always_comb begin
    shift_nxt = shift_r;
    cnt_nxt = cnt_r;
    pend_nxt = pend_r;
    pend_word_nxt = pend_word_r;
    if (pend_r && fifo_in_ready) begin
      pend_nxt = 1'b0;
    end
    // RULE_02: deselected frames drop partial bits
    if (sync2_r.select_n) begin
      cnt_nxt = BIT_CNT_RST;
    // RULE_03: shift on gated clock rise
    end else if (gclk_rise) begin
      shift_nxt = {shift_r[WORD_W-2:0], sync2_r.data};
      cnt_nxt = cnt_r + 1'b1;
      // RULE_11: sixteen bits end a word
      if (cnt_r == BIT_CNT_LAST) begin
        cnt_nxt = BIT_CNT_RST;
        // a word arriving while one still waits is lost; link_busy warns the host
        if (!pend_nxt) begin
          pend_nxt = 1'b1;
          pend_word_nxt = qdc_word_t'(shift_nxt);
        end
      end
    end
  end

  // RULE_09: shift state has no clear path
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      shift_r <= SHIFT_RST;
      cnt_r <= BIT_CNT_RST;
      pend_r <= 1'b0;
      pend_word_r <= qdc_word_t'(SHIFT_RST);
    end else if (clk_en) begin
      shift_r <= shift_nxt;
      cnt_r <= cnt_nxt;
      pend_r <= pend_nxt;
      pend_word_r <= pend_word_nxt;
    end
  end

  qdc_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clock(clock),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .in_valid(pend_r),
    .in_ready(fifo_in_ready),
    .in_data(pend_word_r),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  // input registers frozen while load is low or clear is active
  assign fifo_out_ready = sync2_r.load_n && !clearing;
  assign head = qdc_word_t'(fifo_out_data);
  assign link_busy = pend_r;

  always_comb begin
    in_reg_nxt = in_reg_r;
    dac_nxt = dac_r;
    if (clearing) begin
      // RULE_08: clear both register banks
      // RULE_10: level picks the code
      in_reg_nxt = {CHAN_N{qdc_clear_code(sync2_r.clear_level)}};
      dac_nxt = {CHAN_N{qdc_clear_code(sync2_r.clear_level)}};
    end else begin
      // RULE_06: copy on load fall
      if (load_fall) begin
        dac_nxt = in_reg_r;
      end
      // RULE_12: channel field routes code
      if (fifo_out_valid && fifo_out_ready) begin
        in_reg_nxt[head.chan] = head.code;
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      in_reg_r <= {CHAN_N{CODE_ZERO}};
      dac_r <= {CHAN_N{CODE_ZERO}};
    end else if (clk_en) begin
      in_reg_r <= in_reg_nxt;
      dac_r <= dac_nxt;
    end
  end

  assign dac_codes = dac_r;
  assign input_codes = in_reg_r;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  sequence s_last_bit;
    clk_en && !sync2_r.select_n && gclk_rise && cnt_r == BIT_CNT_LAST;
  endsequence
  sequence s_word_held;
    pend_r && pend_word_r == qdc_word_t'($past(shift_nxt));
  endsequence

  AST_DESELECT_IGNORED: assert property (clk_en && sync2_r.select_n |=> $stable(shift_r) && cnt_r == BIT_CNT_RST) // RULE_02
    else $error("shift state moved while deselected");
  AST_SHIFT_ONE_BIT: assert property (clk_en && gclk_rise && !sync2_r.select_n
      |=> shift_r == {$past(shift_r[WORD_W-2:0]), $past(sync2_r.data)}) // RULE_03
    else $error("bit not shifted on clock rise");
  AST_GATED_CLOCK_HIGH: assert property (clk_en && sync2_r.select_n |=> !gclk_rise) // RULE_05
    else $error("gated clock rose with select high");
  AST_LOAD_COPIES: assert property (clk_en && load_fall && !clearing |=> dac_r == $past(in_reg_r)) // RULE_06
    else $error("load fall did not copy input registers");
  AST_CLEAR_BOTH: assert property (clk_en && clearing
      |=> dac_r == in_reg_r && dac_r[0] == qdc_clear_code($past(sync2_r.clear_level))) // RULE_08
    else $error("clear did not force both banks");
  AST_CLEAR_KEEPS_SHIFT: assert property (clk_en && clearing && !gclk_rise |=> $stable(shift_r)) // RULE_09
    else $error("clear disturbed shift register");
  AST_CLEAR_MID: assert property (clk_en && clearing && sync2_r.clear_level |=> dac_r[3] == CODE_MID) // RULE_10
    else $error("midscale clear code wrong");
  AST_FRAME_WORD: assert property ((s_last_bit and !pend_r) |=> s_word_held) // RULE_11
    else $error("sixteenth bit did not produce a word");
  AST_CHANNEL_ROUTE: assert property (clk_en && fifo_out_valid && fifo_out_ready
      |=> in_reg_r[$past(head.chan)] == $past(head.code)) // RULE_12
    else $error("code not routed to its channel");
endmodule
`default_nettype wire
